// ==== design/psac_core.v ====
// Purpose: acquisition and interface control of a pressure sensor
// Assumes: serial front end decodes frames to a byte register port
// Notes:   conversion engine is outside; this block schedules it
//
// Contract
// - rate field 000 one-shot, 001..111 map 1 to 200 Hz
// - rate codes 110 and 111 force low-noise off
// - rate 000 means power-down, engine off
// - power-down keeps configuration and last output data
// - register port stays alive during power-down
// - one-shot bit starts single acquisition, only valid at rate 000
// - one-shot done: outputs updated, bit self-clears, back to power-down
// - nonzero rate acquires continuously at selected rate
// - filter enable adds pressure low-pass in continuous mode
// - bandwidth odr/2 off; odr/9 or odr/20 by config bit
// - block update holds outputs until all three bytes read
// - wire mode bit: 0 four-wire, 1 three-wire
// - reboot bit reloads trimming from nonvolatile memory
// - reboot bit self-clears after one output-rate period (code: at the next rate tick, or one cycle later in power-down)
// - polarity bit: 0 active-high, 1 active-low pad
// - drive bit: 0 push-pull, 1 open-drain pad
// - auto-increment bit, reset 1, advances address per byte
// - soft reset bit starts reset, self-clears when done
// - soft reset returns volatile registers to defaults
// - low-noise bit selects low-noise only below 100 Hz
`timescale 1ns/1ps
`default_nettype none
`include "psac_defs.vh"

module psac_core #(
    parameter [7:0]  IDENT_VAL = `PSAC_IDENT_VAL, // arbitrary value
    parameter [31:0] PER1 = `PSAC_PER_1HZ_US   * `PSAC_CLK_MHZ,
    parameter [31:0] PER2 = `PSAC_PER_10HZ_US  * `PSAC_CLK_MHZ,
    parameter [31:0] PER3 = `PSAC_PER_25HZ_US  * `PSAC_CLK_MHZ,
    parameter [31:0] PER4 = `PSAC_PER_50HZ_US  * `PSAC_CLK_MHZ,
    parameter [31:0] PER5 = `PSAC_PER_75HZ_US  * `PSAC_CLK_MHZ,
    parameter [31:0] PER6 = `PSAC_PER_100HZ_US * `PSAC_CLK_MHZ,
    parameter [31:0] PER7 = `PSAC_PER_200HZ_US * `PSAC_CLK_MHZ
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        nrst,
    // register port from serial front end
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_ff,
    // conversion engine
    output reg         conv_start_ff,
    input  wire        conv_done,
    input  wire [23:0] conv_press,
    // pressure path filter, low-noise and power steering
    output reg         flt_en_ff,
    output reg  [1:0]  flt_bw_ff,
    output reg         low_noise_ff,
    output reg         powered_ff,
    // interface steering
    output reg         three_wire_ff,
    output reg         addr_inc_ff,
    output reg         irq_active_low_ff,
    output reg         irq_open_drain_ff,
    // trim reload
    output reg         trim_reload_ff,
    // output data
    output reg  [23:0] press_out_ff
);

    ////////////////////////////////////////////////////////////////////
    // registers

    reg  [7:0]  acq_ff;
    reg  [7:0]  ifm_ff;
    reg         busy_ff;
    reg         boot_wait_ff;
    reg  [3:0]  srst_cnt_ff;
    reg  [2:0]  rd_seen_ff;
    reg         held_ff;
    reg  [2:0]  rate_q_ff;

    wire [2:0]  rate = acq_ff[`PSAC_ACQ_RATE_HI:`PSAC_ACQ_RATE_LO];
    wire        tick;
    wire        wr_acq = reg_wr && reg_addr == `PSAC_ADDR_ACQ;
    wire        wr_ifm = reg_wr && reg_addr == `PSAC_ADDR_IFM;
    wire        srst_go = wr_ifm && reg_wdata[`PSAC_IFM_SRST];
    wire        in_srst = ifm_ff[`PSAC_IFM_SRST];
    // mask at full width so the fixed-zero bit stays aligned
    wire [7:0]  ifm_wmask = reg_wdata & `PSAC_IFM_MASK;
    wire        one_go = wr_ifm && reg_wdata[`PSAC_IFM_ONESHOT]
                         && rate == `PSAC_RATE_OFF && !in_srst;

    psac_rate_timer #(
        .PER1 (PER1),
        .PER2 (PER2),
        .PER3 (PER3),
        .PER4 (PER4),
        .PER5 (PER5),
        .PER6 (PER6),
        .PER7 (PER7)
    ) u_timer (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .rate    (rate),
        .restart (rate != rate_q_ff),
        .tick_ff (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // configuration registers

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acq_ff       <= `PSAC_ACQ_RST;
            ifm_ff       <= `PSAC_IFM_RST;
            srst_cnt_ff  <= 4'h0;
            boot_wait_ff <= 1'b0;
            rate_q_ff    <= `PSAC_RATE_OFF;
        end else begin
            rate_q_ff <= rate;
            if (in_srst) begin
                acq_ff <= `PSAC_ACQ_RST;
                if (srst_cnt_ff == `PSAC_SRST_CYC) begin
                    ifm_ff      <= `PSAC_IFM_RST;
                    srst_cnt_ff <= 4'h0;
                end else begin
                    srst_cnt_ff <= srst_cnt_ff + 4'h1;
                end
            end else if (srst_go) begin
                ifm_ff <= `PSAC_IFM_RST | 8'h04;
            end else begin
                if (wr_acq)
                    acq_ff <= reg_wdata & `PSAC_ACQ_MASK;
                if (wr_ifm) begin
                    ifm_ff[7:1] <= ifm_wmask[7:1];
                    ifm_ff[`PSAC_IFM_ONESHOT] <= one_go;
                end else if (conv_done && busy_ff && rate == `PSAC_RATE_OFF)
                begin
                    ifm_ff[`PSAC_IFM_ONESHOT] <= 1'b0;
                end
                // boot clears at the next rate tick, or one cycle later in power-down
                if (wr_ifm && reg_wdata[`PSAC_IFM_BOOT]) begin
                    boot_wait_ff <= 1'b1;
                end else if (ifm_ff[`PSAC_IFM_BOOT] && boot_wait_ff &&
                             (tick || rate == `PSAC_RATE_OFF)) begin
                    ifm_ff[`PSAC_IFM_BOOT] <= 1'b0;
                    boot_wait_ff <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // acquisition scheduling

    // power-down unless continuous or one-shot pending
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_ff       <= 1'b0;
            conv_start_ff <= 1'b0;
            powered_ff    <= 1'b0;
        end else begin
            conv_start_ff <= 1'b0;
            powered_ff    <= (rate != `PSAC_RATE_OFF) || busy_ff || one_go;
            if (in_srst) begin
                busy_ff <= 1'b0;
            end else if (conv_done) begin
                busy_ff <= 1'b0;
            end else if (!busy_ff && (one_go ||
                         (tick && rate != `PSAC_RATE_OFF))) begin
                busy_ff       <= 1'b1;
                conv_start_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output data with block update

    wire rd_xl = reg_rd && reg_addr == `PSAC_ADDR_PXL;
    wire rd_l  = reg_rd && reg_addr == `PSAC_ADDR_PL;
    wire rd_h  = reg_rd && reg_addr == `PSAC_ADDR_PH;
    wire [2:0] seen = rd_seen_ff | {rd_h, rd_l, rd_xl};
    wire blk = acq_ff[`PSAC_ACQ_BLK];

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            press_out_ff <= 24'h00_0000;
            held_ff      <= 1'b0;
            rd_seen_ff   <= 3'h0;
        end else begin
            // release after all three bytes read
            if (held_ff && seen == 3'h7) begin
                held_ff    <= 1'b0;
                rd_seen_ff <= 3'h0;
            end else begin
                rd_seen_ff <= held_ff ? seen : 3'h0;
            end
            // output only loads on a finished conversion
            if (conv_done && busy_ff) begin
                // hold while a held sample is unread or partly read
                if (!blk || !held_ff || seen == 3'h7) begin
                    press_out_ff <= conv_press;
                    held_ff      <= blk;
                    rd_seen_ff   <= 3'h0;
                end
            end
            if (!blk)
                held_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux and steering outputs

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PSAC_ADDR_IDENT: reg_rdata_ff <= IDENT_VAL;
                `PSAC_ADDR_ACQ:   reg_rdata_ff <= acq_ff;
                `PSAC_ADDR_IFM:   reg_rdata_ff <= ifm_ff;
                `PSAC_ADDR_PXL:   reg_rdata_ff <= press_out_ff[7:0];
                `PSAC_ADDR_PL:    reg_rdata_ff <= press_out_ff[15:8];
                `PSAC_ADDR_PH:    reg_rdata_ff <= press_out_ff[23:16];
                default:          reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flt_en_ff         <= 1'b0;
            flt_bw_ff         <= `PSAC_BW_DIV2;
            low_noise_ff      <= 1'b0;
            three_wire_ff     <= 1'b0;
            addr_inc_ff       <= 1'b1;
            irq_active_low_ff <= 1'b0;
            irq_open_drain_ff <= 1'b0;
            trim_reload_ff    <= 1'b0;
        end else begin
            flt_en_ff <= acq_ff[`PSAC_ACQ_FLT_EN] && rate != `PSAC_RATE_OFF;
            if (!acq_ff[`PSAC_ACQ_FLT_EN])
                flt_bw_ff <= `PSAC_BW_DIV2;
            else if (acq_ff[`PSAC_ACQ_FLT_CFG])
                flt_bw_ff <= `PSAC_BW_DIV20;
            else
                flt_bw_ff <= `PSAC_BW_DIV9;
            low_noise_ff <= ifm_ff[`PSAC_IFM_LNOISE] &&
                            rate < `PSAC_RATE_100;
            three_wire_ff <= acq_ff[`PSAC_ACQ_SWM];
            addr_inc_ff <= ifm_ff[`PSAC_IFM_AINC];
            irq_active_low_ff <= ifm_ff[`PSAC_IFM_IRQ_POL];
            irq_open_drain_ff <= ifm_ff[`PSAC_IFM_IRQ_DRV];
            trim_reload_ff <= wr_ifm && reg_wdata[`PSAC_IFM_BOOT] &&
                              !in_srst;
        end
    end

endmodule
`default_nettype wire

// ==== inc/psac_defs.vh ====
// Purpose: register map, field positions and timing constants
// Assumes: 8-bit registers on an internal byte-wide register port
// Notes:   definitions only
`ifndef PSAC_DEFS_VH
`define PSAC_DEFS_VH

`define PSAC_ADDR_IDENT     8'h0F
`define PSAC_ADDR_ACQ       8'h10
`define PSAC_ADDR_IFM       8'h11
`define PSAC_ADDR_PXL       8'h28
`define PSAC_ADDR_PL        8'h29
`define PSAC_ADDR_PH        8'h2A

// acquisition_control fields
`define PSAC_ACQ_RATE_HI    6
`define PSAC_ACQ_RATE_LO    4
`define PSAC_ACQ_FLT_EN     3
`define PSAC_ACQ_FLT_CFG    2
`define PSAC_ACQ_BLK        1
`define PSAC_ACQ_SWM        0
`define PSAC_ACQ_MASK       8'h7F
`define PSAC_ACQ_RST        8'h00

// interface_misc_control fields
`define PSAC_IFM_BOOT       7
`define PSAC_IFM_IRQ_POL    6
`define PSAC_IFM_IRQ_DRV    5
`define PSAC_IFM_AINC       4
`define PSAC_IFM_SRST       2
`define PSAC_IFM_LNOISE     1
`define PSAC_IFM_ONESHOT    0
`define PSAC_IFM_MASK       8'hF7
`define PSAC_IFM_RST        8'h10

// rate codes
`define PSAC_RATE_OFF       3'h0
`define PSAC_RATE_100       3'h6

// bandwidth codes: odr/2, odr/9, odr/20
`define PSAC_BW_DIV2        2'h0
`define PSAC_BW_DIV9        2'h1
`define PSAC_BW_DIV20       2'h2

// rate periods in microseconds, index = rate code
`define PSAC_PER_1HZ_US     1000000
`define PSAC_PER_10HZ_US    100000
`define PSAC_PER_25HZ_US    40000
`define PSAC_PER_50HZ_US    20000
`define PSAC_PER_75HZ_US    13333
`define PSAC_PER_100HZ_US   10000
`define PSAC_PER_200HZ_US   5000
`define PSAC_CLK_MHZ        100

`define PSAC_IDENT_VAL      8'hA5
`define PSAC_SRST_CYC       4'h8

`endif

// ==== design/psac_rate_timer.v ====
// Purpose: output-data-rate tick generator
// Assumes: sys_clk at 100 MHz; period counts given as parameters
// Notes:   restarts on rate change so the first tick is a full period
`timescale 1ns/1ps
`default_nettype none
`include "psac_defs.vh"

module psac_rate_timer #(
    parameter [31:0] PER1 = `PSAC_PER_1HZ_US   * `PSAC_CLK_MHZ,
    parameter [31:0] PER2 = `PSAC_PER_10HZ_US  * `PSAC_CLK_MHZ,
    parameter [31:0] PER3 = `PSAC_PER_25HZ_US  * `PSAC_CLK_MHZ,
    parameter [31:0] PER4 = `PSAC_PER_50HZ_US  * `PSAC_CLK_MHZ,
    parameter [31:0] PER5 = `PSAC_PER_75HZ_US  * `PSAC_CLK_MHZ,
    parameter [31:0] PER6 = `PSAC_PER_100HZ_US * `PSAC_CLK_MHZ,
    parameter [31:0] PER7 = `PSAC_PER_200HZ_US * `PSAC_CLK_MHZ
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        nrst,
    // control
    input  wire [2:0]  rate,
    input  wire        restart,
    // tick out
    output reg         tick_ff
);

    reg  [31:0] cnt_ff;
    reg  [31:0] period;

    always @* begin
        case (rate)
            3'h1: period = PER1;
            3'h2: period = PER2;
            3'h3: period = PER3;
            3'h4: period = PER4;
            3'h5: period = PER5;
            3'h6: period = PER6;
            3'h7: period = PER7;
            default: period = 32'h0000_0001;
        endcase
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (restart || rate == `PSAC_RATE_OFF) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (cnt_ff >= period - 32'h0000_0001) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== tb/psac_core_sva.sv ====
// Purpose: port-level checks of psac_core
// Assumes: one clock, async active-low reset, no writes during soft reset
// Notes:   rate shadow follows writes so steering can be judged
`timescale 1ns/1ps
`default_nettype none
module psac_core_sva #(
    parameter [7:0] IDENT_VAL = 8'hA5 // arbitrary value
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata_ff,
    // conversion engine
    input wire logic        conv_start_ff,
    input wire logic        conv_done,
    input wire logic [23:0] conv_press,
    // steering and data
    input wire logic        flt_en_ff,
    input wire logic [1:0]  flt_bw_ff,
    input wire logic        low_noise_ff,
    input wire logic        powered_ff,
    input wire logic        three_wire_ff,
    input wire logic        addr_inc_ff,
    input wire logic        irq_active_low_ff,
    input wire logic        irq_open_drain_ff,
    input wire logic        trim_reload_ff,
    input wire logic [23:0] press_out_ff
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////
logic [2:0] rate_ff;
wire mapped = reg_addr inside {8'h0F, 8'h10, 8'h11, 8'h28, 8'h29, 8'h2A};
wire srst_wr = reg_wr && reg_addr == 8'h11 && reg_wdata[2];
// soft reset zeroes the rate early; that only loosens the check
always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
        rate_ff <= 3'h0;
    else if (reg_wr && reg_addr == 8'h10)
        rate_ff <= reg_wdata[6:4];
    else if (srst_wr)
        rate_ff <= 3'h0;
end
////////////////////////////////////////////////////////////////////////
a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
a_ident_read: assert property (reg_rd && reg_addr == 8'h0F
    |=> reg_rdata_ff == IDENT_VAL) else $error("identity read wrong");
a_acq_fixed_zero: assert property (reg_rd && reg_addr == 8'h10
    |=> !reg_rdata_ff[7]) else $error("acq bit7 not zero");
a_ifm_fixed_zero: assert property (reg_rd && reg_addr == 8'h11
    |=> !reg_rdata_ff[3]) else $error("ifm bit3 not zero");
a_filter_bw: assert property (flt_en_ff |-> flt_bw_ff inside {2'h1, 2'h2})
    else $error("filter on with odr/2 bandwidth");
a_start_powered: assert property (conv_start_ff |-> powered_ff)
    else $error("conversion started in power-down");
a_start_pulse: assert property (conv_start_ff |=> !conv_start_ff)
    else $error("start longer than one cycle");
a_pd_hold: assert property (!powered_ff |=> $stable(press_out_ff))
    else $error("output data moved in power-down");
a_noise_fast: assert property (low_noise_ff |-> $past(rate_ff) < 3'h6)
    else $error("low-noise on at fast rate");
a_wire_mirror: assert property (reg_wr && reg_addr == 8'h10
    |-> ##2 three_wire_ff == $past(reg_wdata[0], 2))
    else $error("wire mode not following bit");
a_pad_mirror: assert property (reg_wr && reg_addr == 8'h11 && !reg_wdata[2]
    |-> ##2 irq_active_low_ff == $past(reg_wdata[6], 2)
        && irq_open_drain_ff == $past(reg_wdata[5], 2))
    else $error("pad config not following bits");
a_boot_reload: assert property (reg_wr && reg_addr == 8'h11 && reg_wdata[7]
    && !reg_wdata[2] |-> ##[1:2] trim_reload_ff)
    else $error("no trim reload after boot");
a_srst_restore: assert property (srst_wr |-> ##[10:14] addr_inc_ff
    && !three_wire_ff && !irq_open_drain_ff && !irq_active_low_ff)
    else $error("defaults not back after soft reset");
c_start: cover property (conv_start_ff);
c_reload: cover property (trim_reload_ff);
c_noise: cover property (low_noise_ff);
c_filter: cover property (flt_en_ff);
endmodule
bind psac_core psac_core_sva #(.IDENT_VAL(IDENT_VAL)) i_sva (.*);
`default_nettype wire

// ==== tb/psac_conv_model.sv ====
// Purpose: conversion engine standing beside psac_core
// Assumes: one conversion at a time, latency set by the bench
// Notes:   data bus toggles outside done so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module psac_conv_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // conversion handshake
    input  wire logic        conv_start,
    input  wire logic [3:0]  lat,
    output var  logic        conv_done,
    output var  logic [23:0] conv_press,
    // last delivered sample
    output var  logic [23:0] last_sample
);
logic [3:0]  cnt;
logic [23:0] nxt;
always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        cnt <= 4'h0;
        conv_done <= 1'b0;
        conv_press <= 24'h5A5A5A;
        last_sample <= 24'h000000;
        nxt <= 24'h123456;
    end else begin
        conv_done <= 1'b0;
        conv_press <= ~conv_press;
        if (conv_start)
            cnt <= lat;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
            conv_done <= 1'b1;
            conv_press <= nxt;
            last_sample <= nxt;
            nxt <= nxt + 24'h13579B;
        end
    end
end
endmodule
`default_nettype wire

// ==== tb/test_pressure_sensor_acquisition_control.sv ====
// Purpose: self-checking bench for psac_core
// Assumes: inputs change at falling edges; short rate periods for codes 001 and 111 only
// Notes:   one idle cycle between register accesses
`timescale 1ns/1ps
`default_nettype none
`include "psac_defs.vh"
module test_pressure_sensor_acquisition_control;
logic sys_clk, nrst, reg_wr, reg_rd, conv_start_ff, conv_done;
logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, q;
logic [23:0] conv_press, press_out_ff, smp, a;
logic flt_en_ff, low_noise_ff, powered_ff, three_wire_ff, addr_inc_ff;
logic irq_active_low_ff, irq_open_drain_ff, trim_reload_ff;
logic [1:0] flt_bw_ff;
logic [3:0] lat;
logic [31:0] seed, x;
int bad_count, comparisons, n, r;
psac_core #(.PER1(40), .PER7(30)) i_dut (.*);
psac_conv_model i_eng (.sys_clk(sys_clk), .nrst(nrst),
    .conv_start(conv_start_ff), .lat(lat), .conv_done(conv_done),
    .conv_press(conv_press), .last_sample(smp));
initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
end
////////////////////////////////////////////////////////////////////////
function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction
task test_done();
    $display("%0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
        $display("mismatch %s expected %h seen %h", nm, e, g);
        bad_count++;
    end
endtask
task xfer(input logic w, input logic [7:0] ad, input logic [7:0] d);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = ad;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    q = reg_rdata_ff;
    @(negedge sys_clk);
endtask
task rdc(input logic [7:0] ad, input logic [7:0] e);
    xfer(1'b0, ad, 8'h00);
    chk("rdata", e, q);
endtask
task wdone();
    for (n = 0; n < 300 && conv_done !== 1'b1; n++)
        @(negedge sys_clk);
    chk("done seen", 1, conv_done);
    repeat (2) @(negedge sys_clk);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    seed = 32'd11122;
    lat = 4'h5;
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    rdc(8'h0F, 8'hA5);
    rdc(8'h10, 8'h00);
    rdc(8'h11, 8'h10);
    rdc(8'h12, 8'h00);
    chk("pads", 4'h2, {irq_active_low_ff, irq_open_drain_ff, addr_inc_ff,
        three_wire_ff});
    // host sets low-noise here while still in power-down
    for (r = 0; r < 4; r++) begin
        x = xs();
        xfer(1'b1, 8'h11, {1'b0, x[1:0], x[2], 4'hA});
        rdc(8'h11, {1'b0, x[1:0], x[2], 4'h2});
        chk("pads", {x[1:0], x[2]}, {irq_active_low_ff, irq_open_drain_ff,
            addr_inc_ff});
    end
    xfer(1'b1, 8'h10, 8'h80);
    rdc(8'h10, 8'h00);
    for (r = 1; r < 8; r++) begin
        x = xs();
        xfer(1'b1, 8'h10, {1'b0, r[2:0], x[2:1], 1'b0, x[0]});
        rdc(8'h10, {1'b0, r[2:0], x[2:1], 1'b0, x[0]});
        chk("filter", x[2], flt_en_ff);
        chk("bw", x[2] ? (x[1] ? 2 : 1) : 0, flt_bw_ff);
        chk("noise", r < 6, low_noise_ff);
        chk("powered", 1, powered_ff);
        chk("wire", x[0], three_wire_ff);
    end
    wdone();
    xfer(1'b1, 8'h10, 8'h10);
    for (n = 0; n < 100 && conv_start_ff !== 1'b1; n++)
        @(negedge sys_clk);
    @(negedge sys_clk);
    for (n = 1; n < 100 && conv_start_ff !== 1'b1; n++)
        @(negedge sys_clk);
    chk("period", 40, n);
    wdone();
    chk("press", smp, press_out_ff);
    xfer(1'b1, 8'h11, 8'h13);
    rdc(8'h11, 8'h12);
    wdone();
    xfer(1'b1, 8'h10, 8'h02);
    repeat (4) @(negedge sys_clk);
    chk("powered", 0, powered_ff);
    lat = 4'h2;
    xfer(1'b1, 8'h11, 8'h13);
    wdone();
    a = smp;
    chk("press", a, press_out_ff);
    rdc(8'h11, 8'h12);
    repeat (50) @(negedge sys_clk);
    chk("press", a, press_out_ff);
    lat = 4'h9;
    xfer(1'b1, 8'h10, 8'h12);
    wdone();
    chk("held", a, press_out_ff);
    rdc(8'h28, a[7:0]);
    rdc(8'h29, a[15:8]);
    rdc(8'h2A, a[23:16]);
    wdone();
    chk("press", smp, press_out_ff);
    xfer(1'b1, 8'h10, 8'h0F);
    xfer(1'b1, 8'h11, 8'h92);
    rdc(8'h11, 8'h12);
    xfer(1'b1, 8'h11, 8'h74);
    xfer(1'b0, 8'h11, 8'h00);
    chk("srst bit", 1, q[2]);
    repeat (12) @(negedge sys_clk);
    rdc(8'h10, 8'h00);
    rdc(8'h11, 8'h10);
    test_done();
end
initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    test_done();
end
endmodule
`default_nettype wire
